// ### ssi_status_indicator.sv
// Purpose: Status lamps of a fail-safe terminal module
// Assumes: Status bits come from logic on ref_clk_in; channel pins are asynchronous
// Notes: Ready, supply and pair lamp outputs are registered two-bit colour codes; single, output and readback lamps are registered one-bit
// Functional notes
// (R1) Ready lamp steady green when operational and cyclic link traffic runs.
// (R2) Ready lamp steady orange while link communication is being set up.
// (R3) Ready lamp steady red whenever any module fault exists; here red only with module_ok_in high and no download or identify.
// (R4) Red follows fault presence only, not message reconfiguration.
// (R5) Green/red flash at 0.5 Hz while loading, 2 Hz when load done.
// (R6) Identify request flashes green/orange or red/orange, chosen by lamp at activation.
// (R7) Dynamized supply lamp on when fault-free, steady red when faulty.
// (R8) Sensor supply lamp on when fault-free, steady red when faulty.
// (R9) NC/NC pair: second lamp red when the inputs disagree.
// (R10) NC/NO pair: second lamp red when both inputs are equal.
// (R11) NC/NC pair: both lamps green when both inputs carry a signal.
// (R12) NC/NO pair: both lamps green when first has signal, second none.
// (R13) Per-pair contact type: 0 normally-closed, 1 normally-open; default 0.
// (R14) Single input lamp green with signal, off without.
// (R15) Fail-safe output lamp green while the output drives.
// (R16) Readback lamp green when both output lines idle, else off.
// (R17) Flash rates divided from module clock at fifty percent duty.
`timescale 1ns/10ps
module ssi_status_indicator
   import ssi_pkg::*;
#(
   parameter int SLOW_HALF_CYC = SLOW_HALF_DEF,
   parameter int FAST_HALF_CYC = FAST_HALF_DEF
) (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic module_ok_in,
   input wire logic link_cyclic_in,
   input wire logic link_setup_in,
   input wire logic fault_present_in,
   input wire logic fw_loading_in,
   input wire logic fw_done_in,
   input wire logic identify_flash_request_in,
   input wire logic dyn_supply_on_in,
   input wire logic dyn_supply_fault_in,
   input wire logic sensor_supply_on_in,
   input wire logic sensor_supply_fault_in,
   input wire logic [NUM_PAIRS-1:0] contact_type_select_in,
   input wire logic [2*NUM_PAIRS-1:0] safe_input_pair_in,
   input wire logic [NUM_SINGLE-1:0] single_input_in,
   input wire logic [NUM_OUT-1:0] safe_output_drive_in,
   input wire logic [NUM_OUT-1:0] out_line_pos_in,
   input wire logic [NUM_OUT-1:0] out_line_neg_in,
   output logic [1:0] ready_lamp_out,
   output logic [1:0] dynamized_supply_lamp_out,
   output logic [1:0] sensor_supply_lamp_out,
   output logic [4*NUM_PAIRS-1:0] pair_lamp_out,
   output logic [NUM_SINGLE-1:0] single_lamp_out,
   output logic [NUM_OUT-1:0] output_lamp_out,
   output logic [NUM_OUT-1:0] output_readback_input_lamp_out
);

   // ****************************************
   // Pair decode
   // ****************************************
   // Returns {lamp x+1, lamp x}; fault shows on the second lamp only
   function automatic logic [3:0] ssi_pair_decode(input logic a, input logic b,
                                                  input logic ct);
      logic [3:0] res;
      res = {LAMP_OFF, LAMP_OFF};
      if (ct == CONTACT_NC) begin
         if (a != b)
            res = {LAMP_RED, LAMP_OFF}; // [R9]
         else if (a)
            res = {LAMP_GREEN, LAMP_GREEN}; // [R11]
      end else begin
         if (a == b)
            res = {LAMP_RED, LAMP_OFF}; // [R10]
         else if (a)
            res = {LAMP_GREEN, LAMP_GREEN}; // [R12]
      end
      return res;
   endfunction

   // ****************************************
   // Pin synchronisation and flash timing
   // ****************************************
   logic [PIN_W-1:0] pin_raw, pin_s;
   logic [2*NUM_PAIRS-1:0] pair_s;
   logic [NUM_SINGLE-1:0] single_s;
   logic [NUM_OUT-1:0] pos_s, neg_s;
   logic slow_ph, fast_ph;

   assign pin_raw = {out_line_neg_in, out_line_pos_in, single_input_in, safe_input_pair_in};
   assign pair_s = pin_s[2*NUM_PAIRS-1:0];
   assign single_s = pin_s[2*NUM_PAIRS +: NUM_SINGLE];
   assign pos_s = pin_s[2*NUM_PAIRS+NUM_SINGLE +: NUM_OUT];
   assign neg_s = pin_s[2*NUM_PAIRS+NUM_SINGLE+NUM_OUT +: NUM_OUT];

   ssi_sync #(
      .WIDTH(PIN_W)
   ) u_sync (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .async_in(pin_raw),
      .sync_out(pin_s)
   );

   ssi_flash_gen #(
      .SLOW_HALF_CYC(SLOW_HALF_CYC),
      .FAST_HALF_CYC(FAST_HALF_CYC)
   ) u_flash (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .slow_phase_out(slow_ph),
      .fast_phase_out(fast_ph)
   );

   // ****************************************
   // Ready lamp
   // ****************************************
   ssi_rdy_type rdy_mode;
   ssi_lamp_type rdy_lamp_q, rdy_lamp_d;
   logic id_req_q, id_req_d;
   logic base_red_q, base_red_d;

   // Mode priority: firmware load beats identify beats steady colours
   always_comb begin
      rdy_mode = RDY_OFF;
      if (!module_ok_in)
         rdy_mode = RDY_OFF;
      else if (fw_done_in)
         rdy_mode = RDY_DL_DONE; // [R5]
      else if (fw_loading_in)
         rdy_mode = RDY_DL_RUN; // [R5]
      else if (identify_flash_request_in)
         rdy_mode = RDY_IDENT; // [R6]
      else if (fault_present_in)
         rdy_mode = RDY_RED; // [R3] [R4]
      else if (link_setup_in)
         rdy_mode = RDY_ORANGE; // [R2]
      else if (link_cyclic_in)
         rdy_mode = RDY_GREEN; // [R1]
   end

   // Colour pair for identify is frozen at the rising edge of the request
   always_comb begin
      id_req_d = identify_flash_request_in;
      base_red_d = base_red_q;
      if (identify_flash_request_in && !id_req_q)
         base_red_d = (rdy_lamp_q == LAMP_RED); // [R6]
      case (rdy_mode)
         RDY_GREEN: rdy_lamp_d = LAMP_GREEN;
         RDY_ORANGE: rdy_lamp_d = LAMP_ORANGE;
         RDY_RED: rdy_lamp_d = LAMP_RED;
         RDY_DL_RUN: rdy_lamp_d = slow_ph ? LAMP_GREEN : LAMP_RED; // [R5]
         RDY_DL_DONE: rdy_lamp_d = fast_ph ? LAMP_GREEN : LAMP_RED; // [R5]
         RDY_IDENT: begin
            if (!fast_ph)
               rdy_lamp_d = LAMP_ORANGE; // [R6]
            else if (base_red_d)
               rdy_lamp_d = LAMP_RED;
            else
               rdy_lamp_d = LAMP_GREEN;
         end
         default: rdy_lamp_d = LAMP_OFF;
      endcase
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         rdy_lamp_q <= LAMP_OFF;
         id_req_q <= 1'b0;
         base_red_q <= 1'b0;
      end else begin
         rdy_lamp_q <= rdy_lamp_d;
         id_req_q <= id_req_d;
         base_red_q <= base_red_d;
      end
   end

   assign ready_lamp_out = rdy_lamp_q;

   // ****************************************
   // Supply lamps
   // ****************************************
   ssi_lamp_type dyn_lamp_q, dyn_lamp_d, sen_lamp_q, sen_lamp_d;

   // A fault wins over the on indication
   always_comb begin
      dyn_lamp_d = LAMP_OFF;
      sen_lamp_d = LAMP_OFF;
      if (dyn_supply_fault_in)
         dyn_lamp_d = LAMP_RED; // [R7]
      else if (dyn_supply_on_in)
         dyn_lamp_d = LAMP_GREEN; // [R7]
      if (sensor_supply_fault_in)
         sen_lamp_d = LAMP_RED; // [R8]
      else if (sensor_supply_on_in)
         sen_lamp_d = LAMP_GREEN; // [R8]
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         dyn_lamp_q <= LAMP_OFF;
         sen_lamp_q <= LAMP_OFF;
      end else begin
         dyn_lamp_q <= dyn_lamp_d;
         sen_lamp_q <= sen_lamp_d;
      end
   end

   assign dynamized_supply_lamp_out = dyn_lamp_q;
   assign sensor_supply_lamp_out = sen_lamp_q;

   // ****************************************
   // Channel lamps
   // ****************************************
   logic [NUM_PAIRS-1:0] ct_q, ct_d;
   logic [4*NUM_PAIRS-1:0] pair_q, pair_d;
   logic [NUM_SINGLE-1:0] single_q, single_d;
   logic [NUM_OUT-1:0] out_q, out_d, rb_q, rb_d;

   generate
      for (genvar i = 0; i < NUM_PAIRS; i++) begin : g_pair
         assign pair_d[4*i +: 4] = ssi_pair_decode(pair_s[2*i], pair_s[2*i+1], ct_q[i]);
      end
   endgenerate

   // Readback lamp lights only when both lines of the output are idle
   always_comb begin
      ct_d = contact_type_select_in; // [R13]
      single_d = single_s; // [R14]
      out_d = safe_output_drive_in; // [R15]
      rb_d = ~(pos_s | neg_s); // [R16]
   end

   // Contact types fall back to normally-closed on reset
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         ct_q <= CONTACT_RST; // [R13]
         pair_q <= '0;
         single_q <= '0;
         out_q <= '0;
         rb_q <= '0;
      end else begin
         ct_q <= ct_d;
         pair_q <= pair_d;
         single_q <= single_d;
         out_q <= out_d;
         rb_q <= rb_d;
      end
   end

   assign pair_lamp_out = pair_q;
   assign single_lamp_out = single_q;
   assign output_lamp_out = out_q;
   assign output_readback_input_lamp_out = rb_q;

   // ****************************************
   // Checks
   // ****************************************
   default clocking ssi_cb @(posedge ref_clk_in);
   endclocking
   default disable iff (rst_in);

   logic steady_ok;
   assign steady_ok = module_ok_in && !fw_done_in && !fw_loading_in
                      && !identify_flash_request_in;

   ready_green_a: assert property ( // [R1]
      steady_ok && link_cyclic_in && !link_setup_in && !fault_present_in
      |=> ready_lamp_out == LAMP_GREEN)
      else $error("ready lamp not green in cyclic mode");
   ready_orange_a: assert property ( // [R2]
      steady_ok && link_setup_in && !fault_present_in
      |=> ready_lamp_out == LAMP_ORANGE)
      else $error("ready lamp not orange during setup");
   fault_red_a: assert property ( // [R3]
      steady_ok && fault_present_in |=> ready_lamp_out == LAMP_RED)
      else $error("ready lamp not red with fault");
   fault_hold_a: assert property ( // [R4]
      (steady_ok && fault_present_in) [*3] |-> ready_lamp_out == LAMP_RED
      && $past(ready_lamp_out) == LAMP_RED)
      else $error("red lamp dropped while fault stays");
   dl_flash_a: assert property ( // [R5]
      module_ok_in && (fw_loading_in || fw_done_in) |=> ready_lamp_out ==
      (($past(fw_done_in) ? $past(fast_ph) : $past(slow_ph)) ? LAMP_GREEN : LAMP_RED))
      else $error("download flash wrong");
   ident_pair_a: assert property ( // [R6]
      $past(steady_ok) == 1'b0 && module_ok_in && !fw_done_in && !fw_loading_in
      && identify_flash_request_in && id_req_q |=> ready_lamp_out == LAMP_ORANGE
      || ready_lamp_out == ($past(base_red_q) ? LAMP_RED : LAMP_GREEN))
      else $error("identify flash uses wrong pair");
   supply_lamp_a: assert property ( // [R7] [R8]
      dyn_supply_fault_in && sensor_supply_fault_in
      |=> dynamized_supply_lamp_out == LAMP_RED && sensor_supply_lamp_out == LAMP_RED)
      else $error("supply fault not red");
   pair_fault_a: assert property ( // [R9] [R10]
      (pair_s[0] == pair_s[1]) == ct_q[0] |=> pair_lamp_out[3:2] == LAMP_RED)
      else $error("pair discrepancy not red");
   pair_green_a: assert property ( // [R11] [R12]
      pair_s[0] && (pair_s[1] != ct_q[0]) |=> pair_lamp_out[3:0] == 4'h5)
      else $error("pair good state not green");
   contact_rst_a: assert property ( // [R13]
      $past(rst_in) |-> ct_q == CONTACT_RST)
      else $error("contact types not default after reset");
   chan_lamp_a: assert property ( // [R14] [R15] [R16]
      1'b1 |=> single_lamp_out == $past(single_s) && output_lamp_out ==
      $past(safe_output_drive_in) && output_readback_input_lamp_out == ~$past(pos_s | neg_s))
      else $error("channel lamp mismatch");

endmodule

// ### ssi_pkg.sv
// Purpose: Shared constants and types for the safety I/O status lamps
// Assumes: One 50 MHz module clock
// Notes: Lamp colours are two-bit codes driven to a bicolour lamp driver
package ssi_pkg;

   // ****************************************
   // Clock and flash timing
   // ****************************************
   localparam int CLK_HZ = 50_000_000;
   localparam int FLASH_SLOW_MHZ = 500; // 0.5 Hz in millihertz
   localparam int FLASH_FAST_MHZ = 2000; // 2 Hz in millihertz
   localparam int SLOW_HALF_DEF =
      int'(64'(CLK_HZ) * 64'd1000 / (64'd2 * 64'(FLASH_SLOW_MHZ)));
   localparam int FAST_HALF_DEF =
      int'(64'(CLK_HZ) * 64'd1000 / (64'd2 * 64'(FLASH_FAST_MHZ)));
   localparam int FLASH_CNT_W = 27;

   // ****************************************
   // Channel counts
   // ****************************************
   localparam int NUM_PAIRS = 10;
   localparam int NUM_SINGLE = 4;
   localparam int NUM_OUT = 4;
   localparam int PIN_W = 2 * NUM_PAIRS + NUM_SINGLE + 2 * NUM_OUT;

   // ****************************************
   // Reset values and encodings
   // ****************************************
   localparam logic [NUM_PAIRS-1:0] CONTACT_RST = 10'h000; // All normally-closed
   localparam logic CONTACT_NC = 1'h0;
   localparam logic CONTACT_NO = 1'h1;

   typedef enum logic [1:0] {
      LAMP_OFF = 2'h0,
      LAMP_GREEN = 2'h1,
      LAMP_RED = 2'h2,
      LAMP_ORANGE = 2'h3
   } ssi_lamp_type;

   typedef enum logic [2:0] {
      RDY_OFF = 3'h0,
      RDY_GREEN = 3'h1,
      RDY_ORANGE = 3'h2,
      RDY_RED = 3'h3,
      RDY_DL_RUN = 3'h4,
      RDY_DL_DONE = 3'h5,
      RDY_IDENT = 3'h6
   } ssi_rdy_type;

endpackage

// ### ssi_sync.sv
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs are asynchronous to ref_clk_in
// Notes: Stage one feeds stage two only
`timescale 1ns/10ps
module ssi_sync
   import ssi_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // ****************************************
   // Two flops, only the second reads the first
   // ****************************************
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;

endmodule

// ### ssi_flash_gen.sv
// Purpose: Square-wave flash phases divided from the module clock
// Assumes: Half periods of at least two cycles
// Notes: Each phase toggles once per half period, giving even duty
`timescale 1ns/10ps
module ssi_flash_gen
   import ssi_pkg::*;
#(
   parameter int SLOW_HALF_CYC = SLOW_HALF_DEF,
   parameter int FAST_HALF_CYC = FAST_HALF_DEF
) (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   output logic slow_phase_out,
   output logic fast_phase_out
);

   localparam logic [FLASH_CNT_W-1:0] SLOW_LAST = FLASH_CNT_W'(SLOW_HALF_CYC - 1);
   localparam logic [FLASH_CNT_W-1:0] FAST_LAST = FLASH_CNT_W'(FAST_HALF_CYC - 1);

   logic [FLASH_CNT_W-1:0] slow_cnt_q, slow_cnt_d, fast_cnt_q, fast_cnt_d;
   logic slow_ph_q, slow_ph_d, fast_ph_q, fast_ph_d;

   // ****************************************
   // Dividers
   // ****************************************
   // Equal high and low halves keep a 50 percent duty cycle
   always_comb begin
      slow_cnt_d = slow_cnt_q + 1'b1;
      slow_ph_d = slow_ph_q;
      fast_cnt_d = fast_cnt_q + 1'b1;
      fast_ph_d = fast_ph_q;
      if (slow_cnt_q == SLOW_LAST) begin // [R17]
         slow_cnt_d = '0;
         slow_ph_d = ~slow_ph_q;
      end
      if (fast_cnt_q == FAST_LAST) begin // [R17]
         fast_cnt_d = '0;
         fast_ph_d = ~fast_ph_q;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         slow_cnt_q <= '0;
         fast_cnt_q <= '0;
         slow_ph_q <= 1'b1;
         fast_ph_q <= 1'b1;
      end else begin
         slow_cnt_q <= slow_cnt_d;
         fast_cnt_q <= fast_cnt_d;
         slow_ph_q <= slow_ph_d;
         fast_ph_q <= fast_ph_d;
      end
   end

   assign slow_phase_out = slow_ph_q;
   assign fast_phase_out = fast_ph_q;

   // Phase may flip only at the end of a half period
   slow_toggle_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [R17]
      $changed(slow_ph_q) |-> $past(slow_cnt_q) == SLOW_LAST)
      else $error("slow phase flipped mid half period");
   fast_toggle_a: assert property (@(posedge ref_clk_in) disable iff (rst_in) // [R17]
      $changed(fast_ph_q) |-> $past(fast_cnt_q) == FAST_LAST)
      else $error("fast phase flipped mid half period");

endmodule

// ### ssi_link_partner.sv
// Purpose: Drive controller side of the link, as seen by the lamps
// Assumes: Bench commands bring-up; edges taken at falling clock
// Notes: Setup phase length is a plain parameter
`timescale 1ns/10ps
module ssi_link_partner #(
   parameter int SETUP_CYC = 6
) (
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic bring_up_in,
   output logic link_setup_out,
   output logic link_cyclic_out
);
   int cnt_q;
   // Setup phase first, cyclic traffic only after it completes
   always @(negedge ref_clk_in) begin
      if (rst_in || !bring_up_in) begin
         cnt_q <= 0;
         link_setup_out <= 1'h0;
         link_cyclic_out <= 1'h0;
      end else if (cnt_q < SETUP_CYC) begin
         cnt_q <= cnt_q + 1;
         link_setup_out <= 1'h1;
      end else begin
         link_setup_out <= 1'h0;
         link_cyclic_out <= 1'h1;
      end
   end
endmodule

// ### ssi_status_indicator_tb_top.sv
// Purpose: Self-checking bench for the status lamps
// Assumes: Short flash half periods of 8 and 2 cycles
// Notes: Notes queued by the driver, checked by the watcher
`timescale 1ns/10ps
module ssi_status_indicator_tb_top
   import ssi_pkg::*;
   ;
   typedef struct {int kind; logic [39:0] exp; int due;} ssi_note_type;
   localparam int SLOW_H = 8;
   localparam int FAST_H = 2;
   logic ref_clk_in = 1'h0;
   logic rst_in = 1'h1;
   logic ok = 1'h0, fault = 1'h0, load = 1'h0, done = 1'h0, ident = 1'h0, bring = 1'h0;
   logic dyn_on = 1'h0, dyn_f = 1'h0, sen_on = 1'h0, sen_f = 1'h0;
   logic [9:0] ct = 10'h000;
   logic [19:0] pins = 20'h00000;
   logic [3:0] sing = 4'h0, drv = 4'h0, pos = 4'h0, neg = 4'h0;
   logic l_setup, l_cyc;
   logic [1:0] rdy, dyn_l, sen_l, prev;
   logic [39:0] pair_l;
   logic [3:0] sing_l, out_l, rb_l;
   int cyc = 0, ws = 32'h40000000, n_g, n_r, n_o, n_t, num_errors = 0, tests_run = 0, seed;
   ssi_note_type q[$];
   ssi_note_type nt;
   always #10 ref_clk_in = ~ref_clk_in;
   always @(posedge ref_clk_in) cyc <= cyc + 1;
   ssi_link_partner ssi_link_partner_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
      .bring_up_in(bring), .link_setup_out(l_setup), .link_cyclic_out(l_cyc));
   ssi_status_indicator #(.SLOW_HALF_CYC(SLOW_H), .FAST_HALF_CYC(FAST_H)) ssi_status_indicator_i (
      .ref_clk_in(ref_clk_in), .rst_in(rst_in), .module_ok_in(ok), .link_cyclic_in(l_cyc),
      .link_setup_in(l_setup), .fault_present_in(fault), .fw_loading_in(load),
      .fw_done_in(done), .identify_flash_request_in(ident), .dyn_supply_on_in(dyn_on),
      .dyn_supply_fault_in(dyn_f), .sensor_supply_on_in(sen_on),
      .sensor_supply_fault_in(sen_f), .contact_type_select_in(ct), .safe_input_pair_in(pins),
      .single_input_in(sing), .safe_output_drive_in(drv), .out_line_pos_in(pos),
      .out_line_neg_in(neg), .ready_lamp_out(rdy), .dynamized_supply_lamp_out(dyn_l),
      .sensor_supply_lamp_out(sen_l), .pair_lamp_out(pair_l), .single_lamp_out(sing_l),
      .output_lamp_out(out_l), .output_readback_input_lamp_out(rb_l));
   // ****************************************
   // Checking
   // ****************************************
   task automatic cmp_colour(input string nm, input logic [1:0] e, input logic [1:0] s);
      tests_run++;
      if (s !== e) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic cmp_vec(input string nm, input logic [39:0] e, input logic [39:0] s);
      tests_run++;
      if (s !== e) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask
   // Watcher: flash statistics over a 33-sample window, then due notes
   always @(negedge ref_clk_in) begin
      if (cyc >= ws && cyc <= ws + 32) begin
         if (cyc == ws) begin
            n_g = 0; n_r = 0; n_o = 0; n_t = 0;
         end else if (rdy !== prev) n_t++;
         if (cyc < ws + 32) begin
            if (rdy === 2'h1) n_g++;
            if (rdy === 2'h2) n_r++;
            if (rdy === 2'h3) n_o++;
         end
         prev = rdy;
      end
      while (q.size() > 0 && q[0].due <= cyc) begin
         nt = q.pop_front();
         case (nt.kind)
            0: cmp_colour("ready", nt.exp[1:0], rdy);
            1: cmp_colour("dyn supply", nt.exp[1:0], dyn_l);
            2: cmp_colour("sensor supply", nt.exp[1:0], sen_l);
            3: cmp_vec("pairs", nt.exp, pair_l);
            4: cmp_vec("singles", nt.exp, {36'h0, sing_l});
            5: cmp_vec("outputs", nt.exp, {36'h0, out_l});
            6: cmp_vec("readback", nt.exp, {36'h0, rb_l});
            default: cmp_vec("flash", nt.exp,
               {16'h0, 6'(n_g), 6'(n_r), 6'(n_o), 6'(n_t)});
         endcase
      end
   end
   // ****************************************
   // Driving
   // ****************************************
   task automatic note(input int k, input logic [39:0] e, input int d);
      q.push_back('{k, e, cyc + d});
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge ref_clk_in);
   endtask
   // Window opens 3 cycles on, so the new mode has settled
   task automatic flash(input logic [23:0] e);
      ws = cyc + 3;
      note(7, {16'h0, e}, 36);
      tick(38);
   endtask
   function automatic logic [39:0] pair_exp(input logic [9:0] c, input logic [19:0] p);
      logic a, b, err, good;
      pair_exp = 40'h0;
      for (int i = 0; i < NUM_PAIRS; i++) begin
         a = p[2*i];
         b = p[2*i+1];
         err = c[i] ? (a == b) : (a != b);
         good = c[i] ? (a & ~b) : (a & b);
         pair_exp[4*i+:2] = good ? 2'h1 : 2'h0;
         pair_exp[4*i+2+:2] = err ? 2'h2 : (good ? 2'h1 : 2'h0);
      end
   endfunction
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      seed = $urandom(63);
      tick(4);
      rst_in <= 1'h0;
      // Idle output lines after reset already light the readback lamps
      for (int k = 0; k < 7; k++) note(k, (k == 6) ? 40'hF : 40'h0, 1);
      tick(2);
      $display("test reset done");
      ok <= 1'h1;
      bring <= 1'h1;
      note(0, 40'h3, 3);
      note(0, 40'h1, 10);
      tick(12);
      fault <= 1'h1;
      note(0, 40'h2, 4);
      tick(5);
      bring <= 1'h0;
      note(0, 40'h2, 4);
      tick(5);
      ok <= 1'h0;
      note(0, 40'h0, 4);
      tick(5);
      ok <= 1'h1;
      fault <= 1'h0;
      note(0, 40'h0, 4);
      tick(5);
      $display("test ready steady done");
      // Both supplies walk all on/fault combinations, crossed
      for (int i = 0; i < 4; i++) begin
         {dyn_f, dyn_on} <= 2'(i);
         {sen_on, sen_f} <= 2'(i);
         note(1, (i > 1) ? 40'h2 : 40'(i), 4);
         note(2, i[0] ? 40'h2 : 40'(i[1]), 4);
         tick(5);
      end
      $display("test supplies done");
      for (int i = 0; i < 24; i++) begin
         ct <= 10'($urandom);
         pins <= 20'($urandom);
         sing <= 4'($urandom);
         drv <= 4'($urandom);
         pos <= 4'($urandom);
         neg <= 4'($urandom);
         tick(1);
         note(3, pair_exp(ct, pins), 4);
         note(4, {36'h0, sing}, 4);
         note(5, {36'h0, drv}, 4);
         note(6, {36'h0, ~(pos | neg)}, 4);
         tick(5);
      end
      $display("test channels done");
      load <= 1'h1;
      flash({6'h10, 6'h10, 6'h00, 6'(32 / SLOW_H)});
      done <= 1'h1;
      flash({6'h10, 6'h10, 6'h00, 6'(32 / FAST_H)});
      load <= 1'h0;
      done <= 1'h0;
      fault <= 1'h1;
      tick(4);
      ident <= 1'h1;
      flash({6'h00, 6'h10, 6'h10, 6'(32 / FAST_H)});
      ident <= 1'h0;
      fault <= 1'h0;
      bring <= 1'h1;
      tick(12);
      ident <= 1'h1;
      flash({6'h10, 6'h00, 6'h10, 6'(32 / FAST_H)});
      $display("test flashing done");
      // Bounded drain of pending notes
      for (int i = 0; i < 100 && q.size() > 0; i++) tick(1);
      if (q.size() > 0) begin
         num_errors++;
         $display("MISMATCH queue expected empty seen %0d", q.size());
      end
      stop_test();
   end
endmodule
